// file: src/csc_consts.vh
// constants for the clock source control block
// assumes a 32-bit apb slave with byte addresses
`ifndef CSC_CONSTS_VH
`define CSC_CONSTS_VH

// ==========================================
// register byte offsets
`define CSC_OFS_FAST_START    12'h000
`define CSC_OFS_SLOW_START    12'h008
`define CSC_OFS_EVENT_STATUS  12'h100
`define CSC_OFS_INT_EN_SET    12'h304
`define CSC_OFS_INT_EN_CLR    12'h308
`define CSC_OFS_FAST_REQ      12'h408
`define CSC_OFS_FAST_STAT     12'h40c
`define CSC_OFS_SLOW_REQ      12'h414
`define CSC_OFS_SLOW_STAT     12'h418
`define CSC_OFS_SLOW_SNAP     12'h41c
`define CSC_OFS_SLOW_SEL      12'h518
`define CSC_OFS_FAST_DEB      12'h528
`define CSC_OFS_SLOW_DEB      12'h52c

// ==========================================
// event bit positions
`define CSC_EV_FAST_UP        0
`define CSC_EV_SLOW_UP        1
`define CSC_EV_CAL_DONE       2
`define CSC_EV_CAL_TIMEOUT    3
`define CSC_EV_CAL_BEGAN      4
`define CSC_EV_CAL_HALTED     5
`define CSC_EV_COUNT          6

// ==========================================
// slow source select fields
`define CSC_SRC_LSB           0
`define CSC_SRC_MSB           1
`define CSC_BYPASS_BIT        16
`define CSC_EXTERNAL_BIT      17
`define CSC_STATE_BIT         16
`define CSC_SRC_RC            2'h0
`define CSC_SRC_XTAL          2'h1
`define CSC_SRC_SYNTH         2'h2

// ==========================================
// reset values
`define CSC_RST_INT_EN        6'h00
`define CSC_RST_SLOW_SEL      32'h00000000
`define CSC_RST_FAST_DEB      8'h10
`define CSC_RST_SLOW_DEB      8'h10

// ==========================================
// timing
`define CSC_TICK_CYCLES       16

`endif

// file: src/csc_top.v
// clock source control: registers, start sequencing, events
// assumes apb master on i_core_clk; crystal ready pin is asynchronous
//
// Notes on behaviour
// - writing 1 to a disable bit clears that event's enable; reads show enables
// - writing 1 to an enable-set bit sets the same shared enable
// - fast start requested flag sets on fast start task and stays set
// - slow start requested flag sets on slow start task
// - slow status shows active source code and a running bit
// - slow start task copies source select into a read-only snapshot
// - source field is read-write: 0 rc, 1 crystal, 2 synthesized
// - bypass bit 1 bypasses slow crystal with rail-to-rail external clock
// - external bit uses external clock; only valid with crystal source
// - fast start task starts the fast crystal oscillator
// - fast up event after power-up plus programmed debounce time
// - slow start with crystal source starts the slow crystal
// - slow up event after programmed slow debounce time from crystal start
//
// Local design decision: the APB interface to the registers.

`include "csc_consts.vh"

module csc_top #(
	parameter DEB_W       = 8,
	parameter TICK_CYCLES = `CSC_TICK_CYCLES
) (
	input  wire        i_core_clk,
	input  wire        i_rst_b,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	input  wire        i_fast_xtal_powered,
	input  wire        i_cal_done,
	input  wire        i_cal_timeout,
	input  wire        i_cal_began,
	input  wire        i_cal_halted,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	output reg         o_irq,
	output reg         o_fast_xtal_en,
	output reg         o_slow_xtal_en,
	output reg         o_slow_rc_en,
	output reg         o_slow_synth_en,
	output reg         o_slow_bypass,
	output reg         o_slow_external
);

	// ==========================================
	// sequencer states
	localparam [1:0] ST_IDLE     = 2'h0;
	localparam [1:0] ST_POWERUP  = 2'h1;
	localparam [1:0] ST_DEBOUNCE = 2'h2;
	localparam [1:0] ST_RUNNING  = 2'h3;

	localparam [15:0] TICK_LAST = TICK_CYCLES[15:0] - 16'h0001;

	// ==========================================
	// declarations
	reg                       pwr_meta_reg;
	reg                       pwr_sync_reg;
	reg  [15:0]               tick_cnt_reg;
	reg                       tick_reg;
	reg  [`CSC_EV_COUNT-1:0]  int_en_reg;
	reg  [`CSC_EV_COUNT-1:0]  ev_stat_reg;
	reg  [`CSC_EV_COUNT-1:0]  rd_clr_reg;
	reg                       fast_req_reg;
	reg                       slow_req_reg;
	reg  [31:0]               slow_sel_reg;
	reg  [31:0]               slow_snap_reg;
	reg  [DEB_W-1:0]          fast_deb_reg;
	reg  [DEB_W-1:0]          slow_deb_reg;
	reg  [1:0]                fast_st_reg;
	reg  [1:0]                fast_st_next;
	reg  [1:0]                slow_st_reg;
	reg  [1:0]                slow_st_next;
	reg  [DEB_W-1:0]          fast_cnt_reg;
	reg  [DEB_W-1:0]          fast_cnt_next;
	reg  [DEB_W-1:0]          slow_cnt_reg;
	reg  [DEB_W-1:0]          slow_cnt_next;
	reg                       fast_up_pulse;
	reg                       slow_up_pulse;
	reg  [31:0]               rd_data;
	reg                       rd_hit;
	wire                      setup_ph;
	wire                      access_done;
	wire                      wr_done;
	wire                      rd_done;
	wire                      fast_task;
	wire                      slow_task;
	wire                      fast_busy;
	wire                      slow_busy;
	wire [`CSC_EV_COUNT-1:0]  ev_set;
	wire [1:0]                snap_src;

	// ==========================================
	// apb phase decode
	assign setup_ph    = i_psel & ~i_penable;
	assign access_done = i_psel & i_penable & o_pready;
	assign wr_done     = access_done & i_pwrite;
	assign rd_done     = access_done & ~i_pwrite;

	assign fast_task = wr_done & (i_paddr == `CSC_OFS_FAST_START) & i_pwdata[0];
	assign slow_task = wr_done & (i_paddr == `CSC_OFS_SLOW_START) & i_pwdata[0];

	assign fast_busy = (fast_st_reg == ST_POWERUP) | (fast_st_reg == ST_DEBOUNCE);
	assign slow_busy = (slow_st_reg == ST_DEBOUNCE);
	assign snap_src  = slow_snap_reg[`CSC_SRC_MSB:`CSC_SRC_LSB];

	assign ev_set = {i_cal_halted, i_cal_began, i_cal_timeout,
		i_cal_done, slow_up_pulse, fast_up_pulse};

	// ==========================================
	// crystal power-up pin synchroniser
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_meta_reg <= 1'b0;
			pwr_sync_reg <= 1'b0;
		end else begin
			pwr_meta_reg <= i_fast_xtal_powered;
			pwr_sync_reg <= pwr_meta_reg;
		end
	end

	// ==========================================
	// debounce tick divider
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == TICK_LAST) begin
			tick_cnt_reg <= 16'h0000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h0001;
			tick_reg     <= 1'b0;
		end
	end

	// ==========================================
	// read mux
	always @* begin
		rd_data = 32'h00000000;
		rd_hit  = 1'b1;
		case (i_paddr)
			`CSC_OFS_FAST_START: rd_data = 32'h00000000;
			`CSC_OFS_SLOW_START: rd_data = 32'h00000000;
			`CSC_OFS_EVENT_STATUS: rd_data[`CSC_EV_COUNT-1:0] = ev_stat_reg;
			`CSC_OFS_INT_EN_SET: rd_data[`CSC_EV_COUNT-1:0] = int_en_reg;
			`CSC_OFS_INT_EN_CLR: rd_data[`CSC_EV_COUNT-1:0] = int_en_reg;
			`CSC_OFS_FAST_REQ: rd_data[0] = fast_req_reg;
			`CSC_OFS_FAST_STAT: rd_data[0] = (fast_st_reg == ST_RUNNING);
			`CSC_OFS_SLOW_REQ: rd_data[0] = slow_req_reg;
			`CSC_OFS_SLOW_STAT: begin
				rd_data[`CSC_SRC_MSB:`CSC_SRC_LSB] = snap_src;
				rd_data[`CSC_STATE_BIT] = (slow_st_reg == ST_RUNNING);
			end
			`CSC_OFS_SLOW_SNAP: rd_data = slow_snap_reg;
			`CSC_OFS_SLOW_SEL: rd_data = slow_sel_reg;
			`CSC_OFS_FAST_DEB: rd_data[DEB_W-1:0] = fast_deb_reg;
			`CSC_OFS_SLOW_DEB: rd_data[DEB_W-1:0] = slow_deb_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	// ==========================================
	// apb answer: ready one cycle after setup, in the first access cycle
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
			rd_clr_reg <= {`CSC_EV_COUNT{1'b0}};
		end else if (setup_ph) begin
			o_pready  <= 1'b1;
			o_prdata  <= i_pwrite ? 32'h00000000 : rd_data;
			o_pslverr <= ~rd_hit;
			rd_clr_reg <= (!i_pwrite && i_paddr == `CSC_OFS_EVENT_STATUS) ?
				ev_stat_reg : {`CSC_EV_COUNT{1'b0}};
		end else if (access_done) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
			rd_clr_reg <= {`CSC_EV_COUNT{1'b0}};
		end
	end

	// ==========================================
	// interrupt enables and sticky event flags
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			int_en_reg <= `CSC_RST_INT_EN;
		end else if (wr_done && i_paddr == `CSC_OFS_INT_EN_SET) begin
			int_en_reg <= int_en_reg | i_pwdata[`CSC_EV_COUNT-1:0];
		end else if (wr_done && i_paddr == `CSC_OFS_INT_EN_CLR) begin
			int_en_reg <= int_en_reg & ~i_pwdata[`CSC_EV_COUNT-1:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `CSC_EV_COUNT; gi = gi + 1) begin : g_ev
			always @(posedge i_core_clk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					ev_stat_reg[gi] <= 1'b0;
				end else if (ev_set[gi]) begin
					ev_stat_reg[gi] <= 1'b1;
				end else if (rd_done && rd_clr_reg[gi]) begin
					ev_stat_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(ev_stat_reg & int_en_reg);
		end
	end

	// ==========================================
	// configuration registers
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			slow_sel_reg <= `CSC_RST_SLOW_SEL;
		end else if (wr_done && i_paddr == `CSC_OFS_SLOW_SEL) begin
			slow_sel_reg <= 32'h00000000;
			slow_sel_reg[`CSC_SRC_MSB:`CSC_SRC_LSB] <=
				i_pwdata[`CSC_SRC_MSB:`CSC_SRC_LSB];
			slow_sel_reg[`CSC_BYPASS_BIT] <= i_pwdata[`CSC_BYPASS_BIT];
			slow_sel_reg[`CSC_EXTERNAL_BIT] <= i_pwdata[`CSC_EXTERNAL_BIT];
		end
	end

	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fast_deb_reg <= `CSC_RST_FAST_DEB;
		end else if (wr_done && i_paddr == `CSC_OFS_FAST_DEB && !fast_busy) begin
			fast_deb_reg <= i_pwdata[DEB_W-1:0];
		end
	end

	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			slow_deb_reg <= `CSC_RST_SLOW_DEB;
		end else if (wr_done && i_paddr == `CSC_OFS_SLOW_DEB && !slow_busy) begin
			slow_deb_reg <= i_pwdata[DEB_W-1:0];
		end
	end

	// ==========================================
	// start requested flags and source snapshot
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fast_req_reg  <= 1'b0;
			slow_req_reg  <= 1'b0;
			slow_snap_reg <= 32'h00000000;
		end else begin
			if (fast_task) begin
				fast_req_reg <= 1'b1;
			end
			if (slow_task) begin
				slow_req_reg  <= 1'b1;
				slow_snap_reg <= slow_sel_reg;
			end
		end
	end

	// ==========================================
	// fast crystal sequencer
	always @* begin
		fast_st_next  = fast_st_reg;
		fast_cnt_next = fast_cnt_reg;
		fast_up_pulse = 1'b0;
		case (fast_st_reg)
			ST_IDLE: begin
				if (fast_task) begin
					fast_st_next = ST_POWERUP;
				end
			end
			ST_POWERUP: begin
				if (pwr_sync_reg) begin
					fast_st_next  = ST_DEBOUNCE;
					fast_cnt_next = fast_deb_reg;
				end
			end
			ST_DEBOUNCE: begin
				if (fast_cnt_reg == {DEB_W{1'b0}}) begin
					fast_st_next  = ST_RUNNING;
					fast_up_pulse = 1'b1;
				end else if (tick_reg) begin
					fast_cnt_next = fast_cnt_reg - {{(DEB_W-1){1'b0}}, 1'b1};
				end
			end
			ST_RUNNING: begin
				fast_st_next = ST_RUNNING;
			end
			default: begin
				fast_st_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fast_st_reg    <= ST_IDLE;
			fast_cnt_reg   <= {DEB_W{1'b0}};
			o_fast_xtal_en <= 1'b0;
		end else begin
			fast_st_reg    <= fast_st_next;
			fast_cnt_reg   <= fast_cnt_next;
			o_fast_xtal_en <= (fast_st_next != ST_IDLE);
		end
	end

	// ==========================================
	// slow clock sequencer
	always @* begin
		slow_st_next  = slow_st_reg;
		slow_cnt_next = slow_cnt_reg;
		slow_up_pulse = 1'b0;
		if (slow_task) begin
			if (slow_sel_reg[`CSC_SRC_MSB:`CSC_SRC_LSB] == `CSC_SRC_XTAL) begin
				slow_st_next  = ST_DEBOUNCE;
				slow_cnt_next = slow_deb_reg;
			end else begin
				slow_st_next  = ST_POWERUP;
			end
		end else begin
			case (slow_st_reg)
				ST_IDLE: begin
					slow_st_next = ST_IDLE;
				end
				ST_POWERUP: begin
					slow_st_next  = ST_RUNNING;
					slow_up_pulse = 1'b1;
				end
				ST_DEBOUNCE: begin
					if (slow_cnt_reg == {DEB_W{1'b0}}) begin
						slow_st_next  = ST_RUNNING;
						slow_up_pulse = 1'b1;
					end else if (tick_reg) begin
						slow_cnt_next = slow_cnt_reg - {{(DEB_W-1){1'b0}}, 1'b1};
					end
				end
				ST_RUNNING: begin
					slow_st_next = ST_RUNNING;
				end
				default: begin
					slow_st_next = ST_IDLE;
				end
			endcase
		end
	end

	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			slow_st_reg <= ST_IDLE;
			slow_cnt_reg <= {DEB_W{1'b0}};
		end else begin
			slow_st_reg <= slow_st_next;
			slow_cnt_reg <= slow_cnt_next;
		end
	end

	// ==========================================
	// slow oscillator enables from the snapshot
	always @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_slow_xtal_en  <= 1'b0;
			o_slow_rc_en    <= 1'b0;
			o_slow_synth_en <= 1'b0;
			o_slow_bypass   <= 1'b0;
			o_slow_external <= 1'b0;
		end else begin
			o_slow_xtal_en  <= slow_req_reg && snap_src == `CSC_SRC_XTAL;
			o_slow_rc_en    <= slow_req_reg && snap_src == `CSC_SRC_RC;
			o_slow_synth_en <= slow_req_reg && snap_src == `CSC_SRC_SYNTH;
			o_slow_bypass   <= slow_snap_reg[`CSC_BYPASS_BIT];
			o_slow_external <= slow_snap_reg[`CSC_EXTERNAL_BIT]
				&& snap_src == `CSC_SRC_XTAL;
		end
	end

endmodule

// file: tb/csc_xtal_model.sv
// fast crystal model: powered flag after a start-up delay
// assumes enable comes from the block, same clock as the block
module csc_xtal_model #(
	parameter int PWR = 20
) (
	input  wire logic i_clk,
	input  wire logic i_rst_b,
	input  wire logic i_en,
	output logic      o_powered
);
	// ==========================================
	// power-up delay
	int cnt;
	always @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b || !i_en) begin
			cnt <= 0;
			o_powered <= 1'b0;
		end else if (cnt < PWR) begin
			cnt <= cnt + 1;
		end else begin
			o_powered <= 1'b1;
		end
	end
endmodule

// file: tb/csc_top_monitor.sv
// assertions on the clock source control ports
// assumes one clock domain and the apb timing of the design
module csc_top_monitor (
	input wire        i_core_clk,
	input wire        i_rst_b,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire [31:0] o_prdata,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        o_irq,
	input wire        o_fast_xtal_en,
	input wire        o_slow_xtal_en,
	input wire        o_slow_rc_en,
	input wire        o_slow_synth_en,
	input wire        o_slow_external
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// ==========================================
	// helpers
	wire acc = i_psel && i_penable && o_pready && i_pwrite && i_pwdata[0];
	wire fs  = acc && i_paddr == 12'h000;
	wire ss  = acc && i_paddr == 12'h008;
	wire [2:0] slow_en = {o_slow_xtal_en, o_slow_rc_en, o_slow_synth_en};
	// ==========================================
	// checks
	AST_READY_AFTER_SETUP: assert property (i_psel && !i_penable |=> o_pready)
		else $error("no ready after setup");
	AST_READY_PULSE: assert property (o_pready |=> !o_pready)
		else $error("ready longer than one cycle");
	AST_RDATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside answer");
	AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	AST_FAST_HOLD: assert property (o_fast_xtal_en |=> o_fast_xtal_en)
		else $error("fast crystal enable dropped");
	AST_FAST_START: assert property (fs |-> ##[1:2] o_fast_xtal_en)
		else $error("fast crystal not started");
	AST_FAST_CAUSE: assert property ($rose(o_fast_xtal_en) |-> $past(fs, 1) || $past(fs, 2))
		else $error("fast crystal started without task");
	AST_SLOW_ONE: assert property ($onehot0(slow_en))
		else $error("two slow sources enabled");
	AST_SLOW_CAUSE: assert property (!$stable(slow_en) |-> $past(ss, 1) || $past(ss, 2) || $past(ss, 3))
		else $error("slow source changed without task");
	AST_EXT_XTAL: assert property (o_slow_external |-> !o_slow_rc_en && !o_slow_synth_en)
		else $error("external source without crystal option");
	// ==========================================
	// covers
	COV_IRQ: cover property ($rose(o_irq));
	COV_ERR: cover property (o_pslverr);
	COV_EXT: cover property ($rose(o_slow_external));
endmodule

bind csc_top csc_top_monitor u_mon (
	.i_core_clk     (i_core_clk),
	.i_rst_b        (i_rst_b),
	.i_psel         (i_psel),
	.i_penable      (i_penable),
	.i_pwrite       (i_pwrite),
	.i_paddr        (i_paddr),
	.i_pwdata       (i_pwdata),
	.o_prdata       (o_prdata),
	.o_pready       (o_pready),
	.o_pslverr      (o_pslverr),
	.o_irq          (o_irq),
	.o_fast_xtal_en (o_fast_xtal_en),
	.o_slow_xtal_en (o_slow_xtal_en),
	.o_slow_rc_en   (o_slow_rc_en),
	.o_slow_synth_en(o_slow_synth_en),
	.o_slow_external(o_slow_external)
);

// file: tb/tb_csc_top.sv
// testbench for the clock source control block
// assumes apb slave with one access cycle and a fast crystal model
module tb_csc_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PWR = 20;
	logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, err, pwd;
	logic [11:0] addr = 0;
	logic [31:0] wd = 0, rd;
	logic [3:0]  cal = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, fen, sx, src, ssyn, sbyp, sext;
	int          err_count = 0, n_checks = 0, n, k;
	logic [31:0] sel [4] = '{32'h0, 32'h30001, 32'h2, 32'h20001};
	initial forever #5 clk = ~clk;
	csc_top #(.TICK_CYCLES(2)) u_dut (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(addr), .i_pwdata(wd), .i_fast_xtal_powered(pwd), .i_cal_done(cal[0]),
		.i_cal_timeout(cal[1]), .i_cal_began(cal[2]), .i_cal_halted(cal[3]), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .o_irq(irq), .o_fast_xtal_en(fen),
		.o_slow_xtal_en(sx), .o_slow_rc_en(src), .o_slow_synth_en(ssyn), .o_slow_bypass(sbyp),
		.o_slow_external(sext)
	);
	csc_xtal_model #(.PWR(PWR)) u_xtal (.i_clk(clk), .i_rst_b(rst_b), .i_en(fen), .o_powered(pwd));
	// ==========================================
	// tasks
	task automatic final_report();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1; pwr <= w; addr <= a; wd <= d; pen <= 0;
		@(posedge clk);
		pen <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			err_count++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	task automatic wait_irq();
		n = 0;
		while (irq !== 1'b1) begin
			@(posedge clk);
			n++;
			if (n > 400) begin
				err_count++;
				final_report();
			end
		end
	endtask
	// ==========================================
	// sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1;
		rdchk(12'h308, 0);
		rdchk(12'h418, 0);
		rdchk(12'h518, 0);
		rdchk(12'h408, 0);
		rdchk(12'h528, 32'h10);
		rdchk(12'h52c, 32'h10);
		apb(0, 12'hffc, 0);
		chk(err, 1);
		chk(rd, 0);
		apb(1, 12'h304, 32'h3f);
		rdchk(12'h308, 32'h3f);
		apb(1, 12'h308, 32'h05);
		rdchk(12'h304, 32'h3a);
		apb(1, 12'h308, 32'h0);
		rdchk(12'h308, 32'h3a);
		for (k = 2; k < 6; k++) begin
			@(posedge clk);
			cal <= 4'h1 << (k - 2);
			@(posedge clk);
			cal <= 0;
			repeat (3) @(posedge clk);
			chk(irq, k != 2);
			rdchk(12'h100, 32'h1 << k);
			repeat (3) @(posedge clk);
			chk(irq, 0);
		end
		apb(1, 12'h528, 32'h4);
		rdchk(12'h528, 32'h4);
		apb(1, 12'h304, 32'h1);
		apb(1, 12'h000, 32'h1);
		wait_irq();
		chk(n >= PWR + 8 && n <= PWR + 24, 1);
		rdchk(12'h408, 1);
		rdchk(12'h40c, 1);
		rdchk(12'h100, 1);
		apb(1, 12'h000, 32'h1);
		rdchk(12'h408, 1);
		chk(fen, 1);
		apb(1, 12'h52c, 32'h3);
		for (k = 0; k < 4; k++) begin
			apb(1, 12'h518, sel[k]);
			rdchk(12'h518, sel[k]);
			apb(1, 12'h008, 32'h1);
			wait_irq();
			chk(sel[k][1:0] != 2'h1 || n >= 6, 1);
			rdchk(12'h41c, sel[k]);
			rdchk(12'h414, 1);
			rdchk(12'h100, 2);
			rdchk(12'h418, {15'h0, 1'b1, 14'h0, sel[k][1:0]});
			chk({sx, src, ssyn}, {sel[k][1:0] == 1, sel[k][1:0] == 0, sel[k][1:0] == 2});
			chk({sbyp, sext}, {sel[k][16], sel[k][17] && sel[k][1:0] == 1});
		end
		rst_b <= 0;
		repeat (2) @(posedge clk);
		rst_b <= 1;
		rdchk(12'h308, 0);
		chk(fen, 0);
		final_report();
	end
endmodule
